// >>> shared/shift_in_pkg.sv
// constants, register map and state type of the synchronous serial shift-in receiver
package shift_in_pkg;

    // ==========================================================
    // register bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] DATA_OFFSET = 8'h08;
    localparam logic [2:0] COUNT_PAGE = 3'h1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================================
    // control field positions (all inside byte lane 0)
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_NDEST_LSB = 4;
    localparam logic [1:0] CTRL_MODE_RESET = 2'h0;
    localparam logic [2:0] CTRL_NDEST_RESET = 3'h0;

    // status field positions
    localparam int STATUS_BUSY_BIT = 0;
    localparam int STATUS_AVAIL_BIT = 1;
    localparam int STATUS_FULL_BIT = 2;

    // ==========================================================
    // modes: bit 0 selects lsb first, bit 1 selects sampling after the pulse
    localparam logic [1:0] MODE_MSB_FIRST_SAMPLE_BEFORE = 2'h0;
    localparam logic [1:0] MODE_LSB_FIRST_SAMPLE_BEFORE = 2'h1;
    localparam logic [1:0] MODE_MSB_FIRST_SAMPLE_AFTER = 2'h2;
    localparam logic [1:0] MODE_LSB_FIRST_SAMPLE_AFTER = 2'h3;
    localparam int MODE_LSB_FIRST_BIT = 0;
    localparam int MODE_SAMPLE_AFTER_BIT = 1;

    // ==========================================================
    // destination list
    localparam int NUM_DEST = 8;
    localparam int DATA_W = 16;
    localparam logic [4:0] COUNT_RESET = 5'h00;
    localparam logic [4:0] BITS_DEFAULT = 5'h08;
    localparam logic [4:0] BITS_MAX = 5'h10;
    localparam int FIFO_DEPTH = 32;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int T_HIGH_NS = 14000;
    localparam int T_LOW_NS = 46000;
    localparam int HIGH_CYCLES = (T_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LOW_CYCLES = (T_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] HIGH_LOAD = 12'(HIGH_CYCLES - 1);
    localparam logic [11:0] LOW_LOAD = 12'(LOW_CYCLES - 1);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_BIT,
        ST_HIGH,
        ST_LOW,
        ST_PUSH
    } shift_state_type;

endpackage

// >>> hw/shift_fifo.sv
// first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module shift_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int PW = $clog2(DEPTH);

    // ==========================================================
    // state
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0] wptr;
        logic [PW:0] rptr;
    } fifo_state_type;

    fifo_state_type s_reg, s_next;
    logic full;
    logic empty;

    assign empty = (s_reg.wptr == s_reg.rptr);
    assign full = (s_reg.wptr[PW] != s_reg.rptr[PW]) && (s_reg.wptr[PW-1:0] == s_reg.rptr[PW-1:0]);
    // frozen clock enable must also block both handshakes
    assign in_ready = ce && !full;
    assign out_valid = ce && !empty;
    assign out_data = s_reg.mem[s_reg.rptr[PW-1:0]];

    // ==========================================================
    // next state
    always_comb begin
        s_next = s_reg;
        if (in_valid && in_ready) begin
            s_next.mem[s_reg.wptr[PW-1:0]] = in_data;
            s_next.wptr = s_reg.wptr + 1'b1;
        end
        if (out_valid && out_ready) begin
            s_next.rptr = s_reg.rptr + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

endmodule

`default_nettype wire

// >>> hw/sync_serial_shift_in.sv
// synchronous serial shift-in receiver with an axi4-lite register slave
// How it works
// R1 - at the start of a transfer the data pin is released to input so the peripheral drives it.
// R2 - the clock pin is driven as an output through the whole transfer.
// R3 - the clock is first driven low and the data pin made input, and only then do samples and pulses begin.
// R4 - sample-before modes capture the data pin and then issue one clock pulse per bit.
// R5 - sample-after modes issue one clock pulse and then capture the data pin per bit.
// R6 - one sample and one pulse are made per requested bit, so pulses equal bits, then the transfer ends.
// R7 - mode 0 is msb first sampled before the pulse and mode 1 is lsb first sampled before the pulse.
// R8 - mode 2 is msb first sampled after the pulse and mode 3 is lsb first sampled after the pulse.
// R9 - each destination takes 1 to 16 bits, and a count of zero means the default of 8.
// R10 - the clock stays high about 14 us and low about 46 us per bit.
// R11 - a list of destinations with their own counts is filled in list order, one result word each.
// R12 - the peripheral presents its next bit on its own chosen clock edge.
// R13 - each pulse is a high phase then a return low, so the clock idles low between bits and after.
// R14 - msb first puts the first bit at the top of the requested width, lsb first puts it in bit zero.
`timescale 1ns/1ps
`default_nettype none

module sync_serial_shift_in
    import shift_in_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic sdata_oe
);

    // ==========================================================
    // state
    typedef struct packed {
        shift_state_type st;
        logic [1:0] mode;
        logic [2:0] last_dest;
        logic [2:0] dest;
        logic [4:0] bits_left;
        logic [3:0] bit_idx;
        logic [DATA_W-1:0] acc;
        logic [11:0] timer;
        logic sclk;
        logic sclk_oe;
        logic sdata_oe;
        logic [1:0] sync;
        logic [1:0] ctrl_mode;
        logic [2:0] ctrl_ndest;
        logic [NUM_DEST-1:0][4:0] counts;
        logic aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic w_got;
        logic [7:0] wdata;
        logic wlane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } shift_in_state_type;

    shift_in_state_type s_reg, s_next;

    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [DATA_W-1:0] fifo_out_data;
    logic ar_take;
    logic data_bit;

    // ==========================================================
    // buffer between the shifter and software
    shift_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(s_reg.acc),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // ==========================================================
    // outputs
    assign s_axi_awready = ce && !s_reg.aw_got;
    assign s_axi_wready = ce && !s_reg.w_got;
    assign s_axi_arready = ce && !s_reg.rvalid;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    assign sclk_out = s_reg.sclk;
    assign sclk_oe = s_reg.sclk_oe;
    assign sdata_oe = s_reg.sdata_oe;
    assign sdata_out = 1'b0;

    assign ar_take = s_axi_arvalid && s_axi_arready;
    // reading the data word pops it, so a read of an empty buffer pops nothing
    assign fifo_out_ready = ar_take && (s_axi_araddr == DATA_OFFSET);
    assign fifo_in_valid = (s_reg.st == ST_PUSH);
    // second synchroniser stage only
    assign data_bit = s_reg.sync[1];

    // 0 means not supplied, above 16 is held at 16
    function automatic logic [4:0] bits_of(input logic [4:0] count);
        logic [4:0] b;
        b = count;
        if (count == 5'h00) begin
            b = BITS_DEFAULT; // R9
        end else if (count > BITS_MAX) begin
            b = BITS_MAX; // R9
        end
        return b;
    endfunction

    // one received bit folded into the word
    function automatic logic [DATA_W-1:0] capture(
        input logic [DATA_W-1:0] acc,
        input logic [1:0] mode,
        input logic [3:0] idx,
        input logic bit_in
    );
        logic [DATA_W-1:0] r;
        r = acc;
        if (mode[MODE_LSB_FIRST_BIT]) begin
            r[idx] = bit_in; // R14
        end else begin
            r = {acc[DATA_W-2:0], bit_in}; // R14
        end
        return r;
    endfunction

    // ==========================================================
    // next state
    always_comb begin
        s_next = s_reg;
        s_next.sync = {s_reg.sync[0], sdata_in};

        // ---- write channel ----
        if (s_axi_awvalid && s_axi_awready) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_next.w_got = 1'b1;
            s_next.wdata = s_axi_wdata[7:0];
            s_next.wlane0 = s_axi_wstrb[0];
        end
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            if (s_reg.awaddr == CTRL_OFFSET) begin
                if (s_reg.wlane0) begin
                    s_next.ctrl_mode = s_reg.wdata[CTRL_MODE_LSB +: 2];
                    s_next.ctrl_ndest = s_reg.wdata[CTRL_NDEST_LSB +: 3];
                    // a start while busy is dropped; the running list is not disturbed
                    if (s_reg.wdata[CTRL_START_BIT] && s_reg.st == ST_IDLE) begin
                        s_next.st = ST_SETUP;
                        s_next.mode = s_reg.wdata[CTRL_MODE_LSB +: 2]; // R7 R8
                        s_next.last_dest = s_reg.wdata[CTRL_NDEST_LSB +: 3]; // R11
                        s_next.dest = 3'h0; // R11
                        s_next.sclk = 1'b0; // R3
                        s_next.sclk_oe = 1'b1; // R2
                        s_next.sdata_oe = 1'b0; // R1
                        s_next.timer = LOW_LOAD; // R3
                    end
                end
            end else if (s_reg.awaddr[7:5] == COUNT_PAGE && s_reg.awaddr[1:0] == 2'h0) begin
                if (s_reg.wlane0) begin
                    s_next.counts[s_reg.awaddr[4:2]] = s_reg.wdata[4:0]; // R9
                end
            end else if (s_reg.awaddr != STATUS_OFFSET && s_reg.awaddr != DATA_OFFSET) begin
                s_next.bresp = RESP_SLVERR;
            end
        end

        // ---- read channel ----
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
        end
        if (ar_take) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            s_next.rdata = 32'h0000_0000;
            if (s_axi_araddr == CTRL_OFFSET) begin
                s_next.rdata[CTRL_MODE_LSB +: 2] = s_reg.ctrl_mode;
                s_next.rdata[CTRL_NDEST_LSB +: 3] = s_reg.ctrl_ndest;
            end else if (s_axi_araddr == STATUS_OFFSET) begin
                s_next.rdata[STATUS_BUSY_BIT] = (s_reg.st != ST_IDLE);
                s_next.rdata[STATUS_AVAIL_BIT] = fifo_out_valid;
                s_next.rdata[STATUS_FULL_BIT] = !fifo_in_ready;
            end else if (s_axi_araddr == DATA_OFFSET) begin
                if (fifo_out_valid) begin
                    s_next.rdata[DATA_W-1:0] = fifo_out_data;
                end
            end else if (s_axi_araddr[7:5] == COUNT_PAGE && s_axi_araddr[1:0] == 2'h0) begin
                s_next.rdata[4:0] = s_reg.counts[s_axi_araddr[4:2]];
            end else begin
                s_next.rresp = RESP_SLVERR;
            end
        end

        // ---- shifter ----
        case (s_reg.st)
            ST_IDLE: begin
                s_next.sclk = 1'b0; // R13
            end
            ST_SETUP: begin
                // clock held low one full low phase before the first bit
                if (s_reg.timer == 12'h000) begin
                    s_next.bits_left = bits_of(s_reg.counts[s_reg.dest]); // R9
                    s_next.bit_idx = 4'h0;
                    s_next.acc = '0;
                    s_next.st = ST_BIT; // R3
                end else begin
                    s_next.timer = s_reg.timer - 12'h001;
                end
            end
            ST_BIT: begin
                if (!s_reg.mode[MODE_SAMPLE_AFTER_BIT]) begin
                    s_next.acc = capture(s_reg.acc, s_reg.mode, s_reg.bit_idx, data_bit); // R4
                    s_next.bit_idx = s_reg.bit_idx + 4'h1;
                end
                s_next.sclk = 1'b1; // R13
                s_next.timer = HIGH_LOAD; // R10
                s_next.st = ST_HIGH;
            end
            ST_HIGH: begin
                if (s_reg.timer == 12'h000) begin
                    s_next.sclk = 1'b0; // R13
                    s_next.timer = LOW_LOAD; // R10
                    s_next.st = ST_LOW;
                end else begin
                    s_next.timer = s_reg.timer - 12'h001;
                end
            end
            ST_LOW: begin
                if (s_reg.timer == 12'h000) begin
                    if (s_reg.mode[MODE_SAMPLE_AFTER_BIT]) begin
                        s_next.acc = capture(s_reg.acc, s_reg.mode, s_reg.bit_idx, data_bit); // R5
                        s_next.bit_idx = s_reg.bit_idx + 4'h1;
                    end
                    s_next.bits_left = s_reg.bits_left - 5'h01; // R6
                    s_next.st = (s_reg.bits_left == 5'h01) ? ST_PUSH : ST_BIT; // R6
                end else begin
                    s_next.timer = s_reg.timer - 12'h001;
                end
            end
            ST_PUSH: begin
                // a full buffer stalls here with the clock low, no bit is lost
                if (fifo_in_ready) begin
                    if (s_reg.dest == s_reg.last_dest) begin
                        s_next.st = ST_IDLE; // R6
                    end else begin
                        s_next.dest = s_reg.dest + 3'h1; // R11
                        s_next.bits_left = bits_of(s_reg.counts[s_reg.dest + 3'h1]); // R11
                        s_next.bit_idx = 4'h0;
                        s_next.acc = '0;
                        s_next.st = ST_BIT;
                    end
                end
            end
            default: begin
                s_next.st = ST_IDLE;
                s_next.sclk = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
            s_reg.ctrl_mode <= CTRL_MODE_RESET;
            s_reg.ctrl_ndest <= CTRL_NDEST_RESET;
            s_reg.counts <= {NUM_DEST{COUNT_RESET}};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

endmodule

`default_nettype wire

// >>> verif/shift_peripheral_model.sv
// behavioural shift-register peripheral on the far side of the serial link
`timescale 1ns/1ps
`default_nettype none
module shift_peripheral_model (
    input wire logic sclk,
    input wire logic load,
    input wire logic post,
    input wire logic slow,
    input wire logic [31:0] pattern,
    input wire logic [5:0] nbits,
    output logic sdata
);
    // ==========
    // model
    // pos -1 is the dummy bit a post-clock part shows before its first edge
    int pos;
    task automatic show();
        if (pos < 0) sdata = ~pattern[0];
        else if (pos < int'(nbits)) sdata = pattern[pos];
        else sdata = ~sdata; // released line: never a stale last bit
    endtask
    initial sdata = 1'b0;
    always @(posedge load) begin
        pos = post ? -1 : 0;
        show();
    end
    always @(posedge sclk) begin
        pos++;
        #(slow ? 5000 : 1) show();
    end
endmodule
`default_nettype wire

// >>> verif/shift_in_checker.sv
// port assertions of the shift-in receiver
`timescale 1ns/1ps
`default_nettype none
module shift_in_checker
    import shift_in_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic sdata_out,
    input wire logic sdata_oe
);
    // ==========
    // phase run lengths, saturated so long idle time cannot wrap
    logic [11:0] hi_cnt;
    logic [11:0] lo_cnt;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hi_cnt <= 12'h000;
            lo_cnt <= 12'h000;
        end else begin
            hi_cnt <= sclk_out ? hi_cnt + {11'h000, hi_cnt != 12'hfff} : 12'h000;
            lo_cnt <= sclk_out ? 12'h000 : lo_cnt + {11'h000, lo_cnt != 12'hfff};
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_pulse_end;
        $fell(sclk_out);
    endsequence
    // ==========
    // assertions
    a_data_pin_input: assert property (!sdata_oe && !sdata_out)
        else $error("data pin driven");
    a_clock_pin_driven: assert property (sclk_out |-> sclk_oe)
        else $error("clock high without enable");
    a_setup_clock_low: assert property ($rose(sclk_oe) |-> !sclk_out [*8])
        else $error("clock not low at setup");
    a_high_phase_width: assert property (s_pulse_end |-> hi_cnt == 12'(HIGH_CYCLES))
        else $error("high phase length wrong");
    a_low_phase_width: assert property ($rose(sclk_out) |-> lo_cnt >= 12'(LOW_CYCLES))
        else $error("low phase too short");
    a_write_response: assert property (s_write_taken |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while data pending");
endmodule
bind sync_serial_shift_in shift_in_checker u_chk (.clk_sys, .resetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .sclk_out, .sclk_oe, .sdata_out, .sdata_oe);
`default_nettype wire

// >>> verif/sync_serial_shift_in_tb_top.sv
// self-checking bench for the shift-in receiver
`timescale 1ns/1ps
`default_nettype none
module sync_serial_shift_in_tb_top;
    import shift_in_pkg::*;
    logic clk_sys, resetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, sclk_out, sclk_oe, sdata_in, m_load, m_post, m_slow;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, m_pat;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] m_nbits;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int failures, samples_checked, pulses;
    sync_serial_shift_in dut (.clk_sys, .resetn, .ce, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .sclk_out, .sclk_oe, .sdata_in, .sdata_out(), .sdata_oe());
    shift_peripheral_model peer (.sclk(sclk_out), .load(m_load), .post(m_post),
        .slow(m_slow), .pattern(m_pat), .nbits(m_nbits), .sdata(sdata_in));
    // ==========
    // checking
    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic give_up();
        failures++;
        summarize();
    endtask
    always @(posedge sclk_out) pulses++;
    // the monitor owns every bus comparison; drivers only queue expectations
    always @(posedge clk_sys) begin
        if (s_axi_rvalid && s_axi_rready)
            check("read", {s_axi_rresp, s_axi_rdata}, rq.size() != 0 ? rq.pop_front() : 34'bx);
        if (s_axi_bvalid && s_axi_bready)
            check("bresp", {32'h0, s_axi_bresp}, bq.size() != 0 ? {32'h0, bq.pop_front()} : 34'bx);
    end
    // ==========
    // bus master; ready is raised late on purpose so the slave must hold its answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        int n;
        logic ta, tw, tb;
        bq.push_back(resp);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 200; n++) begin
            if (n == 3) s_axi_bready <= 1'b1;
            @(negedge clk_sys);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) break;
        end
        s_axi_bready <= 1'b0;
        if (n == 200) give_up();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        int n;
        logic tr, tv;
        rq.push_back({resp, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 200; n++) begin
            if (n == 2) s_axi_rready <= 1'b1;
            @(negedge clk_sys);
            tr = s_axi_arvalid && s_axi_arready;
            tv = s_axi_rvalid && s_axi_rready;
            @(posedge clk_sys);
            if (tr) s_axi_arvalid <= 1'b0;
            if (tv) break;
        end
        s_axi_rready <= 1'b0;
        if (n == 200) give_up();
    endtask
    function automatic logic [31:0] pack(input logic [31:0] p, input int f, input int n,
        input logic lsb);
        logic [31:0] w;
        w = 32'h0;
        for (int i = 0; i < n; i++) w[lsb ? i : n - 1 - i] = p[f + i];
        return w;
    endfunction
    task automatic wait_pulses(input int want);
        int n;
        // bounded so that one hang still ends the whole run at most 30000 cycles after this wait begins
        for (n = 0; n < 30000 && pulses < want; n++) @(posedge clk_sys);
        if (pulses < want) give_up();
    endtask
    // ==========
    // one transfer: program counts, arm the peer, start, then drain the results
    task automatic run(input logic [1:0] mode, input int nd, input int c0, input int c1,
        input logic busy_start, input logic slow);
        int k0, k1, tot;
        k0 = c0 == 0 ? 8 : c0;
        k1 = nd < 2 ? 0 : (c1 == 0 ? 8 : c1);
        tot = k0 + k1;
        wr({COUNT_PAGE, 3'h0, 2'h0}, 32'(c0), RESP_OKAY);
        wr({COUNT_PAGE, 3'h1, 2'h0}, 32'(c1), RESP_OKAY);
        m_pat <= $urandom();
        m_post <= mode[1];
        m_slow <= slow;
        m_nbits <= 6'(tot);
        m_load <= 1'b1;
        @(posedge clk_sys);
        m_load <= 1'b0;
        pulses = 0;
        wr(CTRL_OFFSET, {25'h0, 3'(nd - 1), 1'b0, mode, 1'b1}, RESP_OKAY);
        if (busy_start) begin
            wait_pulses(1);
            rd(STATUS_OFFSET, 32'h1, RESP_OKAY);
            wr(CTRL_OFFSET, {25'h0, 3'(nd - 1), 1'b0, ~mode, 1'b1}, RESP_OKAY);
            rd(CTRL_OFFSET, {25'h0, 3'(nd - 1), 1'b0, ~mode, 1'b0}, RESP_OKAY);
        end
        wait_pulses(tot);
        // the last pulse still has its high and low phase and the push ahead of it
        repeat (HIGH_CYCLES + LOW_CYCLES + 20) @(posedge clk_sys);
        check("pulses", 34'(pulses), 34'(tot));
        rd(STATUS_OFFSET, 32'h2, RESP_OKAY);
        rd(DATA_OFFSET, pack(m_pat, 0, k0, mode[0]), RESP_OKAY);
        if (nd > 1) rd(DATA_OFFSET, pack(m_pat, k0, k1, mode[0]), RESP_OKAY);
        rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        void'($urandom(32'hb165));
        {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {m_load, m_post, m_slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {m_pat, m_nbits} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        rd(CTRL_OFFSET, 32'h0, RESP_OKAY);
        rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
        rd(DATA_OFFSET, 32'h0, RESP_OKAY);
        rd({COUNT_PAGE, 3'h7, 2'h0}, 32'h0, RESP_OKAY);
        wr({COUNT_PAGE, 3'h7, 2'h0}, 32'h0000000b, RESP_OKAY);
        rd({COUNT_PAGE, 3'h7, 2'h0}, 32'h0000000b, RESP_OKAY);
        rd(8'h10, 32'h0, RESP_SLVERR);
        wr(8'h10, $urandom(), RESP_SLVERR);
        wr(STATUS_OFFSET, $urandom(), RESP_OKAY);
        rd(STATUS_OFFSET, 32'h0, RESP_OKAY);
        run(MODE_MSB_FIRST_SAMPLE_BEFORE, 1, 0, 0, 1'b0, 1'b0);
        run(MODE_LSB_FIRST_SAMPLE_BEFORE, 1, 4, 0, 1'b0, 1'b0);
        run(MODE_MSB_FIRST_SAMPLE_AFTER, 2, 3, 1, 1'b1, 1'b0);
        run(MODE_LSB_FIRST_SAMPLE_AFTER, 1, 5, 0, 1'b0, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
